//--- pkg/cid_cfg.svh
// Constants of the object dictionary: object indexes, fixed values, abort codes, timing.
`ifndef CID_CFG_SVH
`define CID_CFG_SVH

// ----------------------------------------
// Object indexes
// ----------------------------------------
`define CID_IDX_NMT 16'h0000
`define CID_IDX_PROFILE 16'h1000
`define CID_IDX_FAULT 16'h1001
`define CID_IDX_SYNC 16'h1005
`define CID_IDX_NAME 16'h1008
`define CID_IDX_HEARTBEAT 16'h1017
`define CID_IDX_IDENTITY 16'h1018
`define CID_IDX_VALVE_PART 16'h2049
`define CID_IDX_VALVE_REV 16'h204A
`define CID_IDX_VALVE_SER 16'h204B

// ----------------------------------------
// Fixed values and identity sub-indexes
// ----------------------------------------
`define CID_PROFILE_VAL 32'h0000_0000
`define CID_SYNC_VAL 32'h0000_0080
`define CID_ID_ENTRIES 8'h08
`define CID_SUB_VALVE_PART 8'h05
`define CID_SUB_VALVE_REV 8'h06
`define CID_SUB_VALVE_SER 8'h07
`define CID_REV_BASE 16'h0001
`define CID_REV_PRELIM_BASE 16'h0064

// ----------------------------------------
// Abort codes
// ----------------------------------------
`define CID_ABT_READ_ONLY 32'h0601_0002
`define CID_ABT_WRITE_ONLY 32'h0601_0001
`define CID_ABT_NO_OBJECT 32'h0602_0000
`define CID_ABT_NO_SUB 32'h0609_0011

// ----------------------------------------
// Timing
// ----------------------------------------
`define CID_CLK_PERIOD_PS 4000
`define CID_MS_PS 1000000000
`define CID_MS_CYCLES (`CID_MS_PS / `CID_CLK_PERIOD_PS)

`endif

//--- pkg/cid_pkg.sv
// Types shared by the object dictionary and its users.
package cid_pkg;

	// SDO request as seen by the dictionary
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] index;
		logic [7:0] subindex;
		logic [31:0] wdata;
	} cid_req_t;

	// SDO answer
	typedef struct packed {
		logic valid;
		logic abort;
		logic [31:0] data;
		logic [31:0] abort_code;
	} cid_rsp_t;

	// Identity figures supplied by the node
	typedef struct packed {
		logic [31:0] product_code;
		logic [31:0] product_serial;
		logic [31:0] valve_code;
		logic [31:0] valve_serial;
		logic [31:0] valve_type;
		logic [15:0] can_major;
		logic [7:0] part_rev_step;
		logic part_rev_prelim;
		logic [7:0] valve_rev_step;
		logic valve_rev_prelim;
	} cid_ident_t;

endpackage : cid_pkg

//--- verilog/cid_dictionary.sv
// Object dictionary of the node: SDO answers and heartbeat timing.
`timescale 1ns/1ps
`include "cid_cfg.svh"

module cid_dictionary import cid_pkg::*; #(
	parameter int MS_CYCLES = `CID_MS_CYCLES,
	parameter logic [31:0] VENDOR_CODE = 32'h0000_5A5A, // Arbitrary value
	parameter logic [31:0] NAME_TEXT = 32'h4E4F_4445 // Arbitrary value, "NODE"
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire cid_req_t req,
	input wire cid_ident_t ident,
	input wire logic [7:0] fault_summary,
	input wire logic [15:0] heartbeat_period_ms,
	output cid_rsp_t rsp_r,
	output logic hb_pulse_r,
	output logic [15:0] nmt_cmd_r,
	output logic nmt_strobe_r
);

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (MS_CYCLES < 1) begin : g_bad_ms
		$error("MS_CYCLES must be at least one");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Numeric revision: release steps from 1, preliminary steps from 100
	function automatic logic [15:0] rev_code(input logic [7:0] step, input logic prelim);
		logic [15:0] base;
		base = prelim ? `CID_REV_PRELIM_BASE : `CID_REV_BASE;
		if (prelim) begin
			rev_code = base + {8'h00, step};
		end else begin
			rev_code = base + {8'h00, step};
		end
	endfunction : rev_code

	// One identity record word per sub-index
	function automatic logic [31:0] ident_word(input cid_ident_t id, input logic [7:0] sub);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (sub)
			8'h00: w = {24'h00_0000, `CID_ID_ENTRIES};
			8'h01: w = VENDOR_CODE;
			8'h02: w = id.product_code;
			8'h03: w = {id.can_major, rev_code(id.part_rev_step, id.part_rev_prelim)};
			8'h04: w = id.product_serial;
			8'h05: w = id.valve_code;
			8'h06: w = {16'h0000, rev_code(id.valve_rev_step, id.valve_rev_prelim)};
			8'h07: w = id.valve_serial;
			8'h08: w = id.valve_type;
			default: w = 32'h0000_0000;
		endcase
		ident_word = w;
	endfunction : ident_word

	// ----------------------------------------
	// Sampled node values
	// ----------------------------------------
	logic [7:0] fault_r;
	logic [15:0] period_r;

	// Error summary and heartbeat period follow the node each cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			fault_r <= 8'h00;
			period_r <= 16'h0000;
		end else begin
			fault_r <= fault_summary;
			period_r <= heartbeat_period_ms;
		end
	end

	// ----------------------------------------
	// Object decode
	// ----------------------------------------
	logic found;
	logic sub_ok;
	logic writable;
	logic [31:0] rd_data;
	cid_rsp_t rsp_nxt;

	// Look up the addressed object
	always_comb begin
		found = 1'b1;
		sub_ok = (req.subindex == 8'h00);
		writable = 1'b0;
		rd_data = 32'h0000_0000;
		if (req.index == `CID_IDX_NMT) begin
			writable = 1'b1;
		end else if (req.index == `CID_IDX_PROFILE) begin
			rd_data = `CID_PROFILE_VAL;
		end else if (req.index == `CID_IDX_FAULT) begin
			rd_data = {24'h00_0000, fault_r};
		end else if (req.index == `CID_IDX_SYNC) begin
			rd_data = `CID_SYNC_VAL;
		end else if (req.index == `CID_IDX_NAME) begin
			rd_data = NAME_TEXT;
		end else if (req.index == `CID_IDX_HEARTBEAT) begin
			rd_data = {16'h0000, period_r};
		end else if (req.index == `CID_IDX_IDENTITY) begin
			sub_ok = (req.subindex <= `CID_ID_ENTRIES);
			rd_data = ident_word(ident, req.subindex);
		end else if (req.index == `CID_IDX_VALVE_PART) begin
			rd_data = ident_word(ident, `CID_SUB_VALVE_PART);
		end else if (req.index == `CID_IDX_VALVE_REV) begin
			rd_data = ident_word(ident, `CID_SUB_VALVE_REV);
		end else if (req.index == `CID_IDX_VALVE_SER) begin
			rd_data = ident_word(ident, `CID_SUB_VALVE_SER);
		end else begin
			found = 1'b0;
		end
	end

	// Build the answer, aborting bad accesses
	always_comb begin
		rsp_nxt = '0;
		rsp_nxt.valid = req.valid;
		if (!found) begin
			rsp_nxt.abort = req.valid;
			rsp_nxt.abort_code = `CID_ABT_NO_OBJECT;
		end else if (!sub_ok) begin
			rsp_nxt.abort = req.valid;
			rsp_nxt.abort_code = `CID_ABT_NO_SUB;
		end else if (req.write && !writable) begin
			rsp_nxt.abort = req.valid;
			rsp_nxt.abort_code = `CID_ABT_READ_ONLY;
		end else if (!req.write && writable) begin
			rsp_nxt.abort = req.valid;
			rsp_nxt.abort_code = `CID_ABT_WRITE_ONLY;
		end else if (!req.write) begin
			rsp_nxt.data = rd_data;
		end
		if (!req.valid) begin
			rsp_nxt = '0;
		end
	end

	// Answer register, one cycle after the request
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rsp_r <= '0;
		end else begin
			rsp_r <= rsp_nxt;
		end
	end

	// ----------------------------------------
	// Network management command
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			nmt_cmd_r <= 16'h0000;
			nmt_strobe_r <= 1'b0;
		end else begin
			nmt_strobe_r <= req.valid && req.write && writable && sub_ok;
			if (req.valid && req.write && writable && sub_ok) begin
				nmt_cmd_r <= req.wdata[15:0];
			end
		end
	end

	// ----------------------------------------
	// Heartbeat timing
	// ----------------------------------------
	logic [$clog2(MS_CYCLES + 1)-1:0] tick_r;
	logic [15:0] ms_r;
	logic ms_tick;

	assign ms_tick = (tick_r == ($bits(tick_r))'(MS_CYCLES - 1));

	// Millisecond prescaler and period counter; idle while period is zero
	always_ff @(posedge clock) begin
		if (sys_rst || period_r == 16'h0000) begin
			tick_r <= '0;
			ms_r <= 16'h0000;
			hb_pulse_r <= 1'b0;
		end else begin
			hb_pulse_r <= 1'b0;
			if (ms_tick) begin
				tick_r <= '0;
				if (ms_r >= period_r - 16'h0001) begin
					ms_r <= 16'h0000;
					hb_pulse_r <= 1'b1;
				end else begin
					ms_r <= ms_r + 16'h0001;
				end
			end else begin
				tick_r <= tick_r + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_read(logic [15:0] idx, logic [7:0] sub);
		req.valid && !req.write && req.index == idx && req.subindex == sub;
	endsequence

	sequence s_write(logic [15:0] idx);
		req.valid && req.write && req.index == idx;
	endsequence

	a_profile_zero: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_PROFILE, 8'h00) |=> rsp_r.valid && !rsp_r.abort && rsp_r.data == 32'h0)
		else $error("device type not zero");

	a_sync_const: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_SYNC, 8'h00) |=> rsp_r.data == 32'h0000_0080 && !rsp_r.abort)
		else $error("sync identifier wrong");

	a_hb_report: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_HEARTBEAT, 8'h00) |=> rsp_r.data == {16'h0000, $past(period_r)})
		else $error("heartbeat period misreported");

	a_hb_silent: assert property (@(posedge clock) disable iff (sys_rst)
		period_r == 16'h0000 ##1 period_r == 16'h0000 |-> !hb_pulse_r)
		else $error("heartbeat sent while disabled");

	a_ident_count: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_IDENTITY, 8'h00) |=> rsp_r.data == 32'h0000_0008)
		else $error("identity entry count wrong");

	a_rev_major: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_IDENTITY, 8'h03) |=> rsp_r.data[31:16] == $past(ident.can_major))
		else $error("major revision misplaced");

	a_rev_release: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_IDENTITY, 8'h03) ##0 !ident.part_rev_prelim
		|=> rsp_r.data[15:0] == {8'h00, $past(ident.part_rev_step)} + 16'd1)
		else $error("release revision encoding wrong");

	a_rev_prelim: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_IDENTITY, 8'h03) ##0 ident.part_rev_prelim
		|=> rsp_r.data[15:0] == {8'h00, $past(ident.part_rev_step)} + 16'd100)
		else $error("preliminary revision encoding wrong");

	a_valve_rev: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_VALVE_REV, 8'h00) |=> rsp_r.data[15:0] ==
		({8'h00, $past(ident.valve_rev_step)} + ($past(ident.valve_rev_prelim) ? 16'd100 : 16'd1)))
		else $error("valve revision encoding wrong");

	a_fault_width: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_FAULT, 8'h00)
		|=> rsp_r.data[31:8] == 24'h0 && rsp_r.data[7:0] == $past(fault_r))
		else $error("error register wrong");

	a_ro_abort: assert property (@(posedge clock) disable iff (sys_rst)
		req.valid && req.write && req.index != `CID_IDX_NMT
		|=> rsp_r.valid && rsp_r.abort && !nmt_strobe_r)
		else $error("write to read-only object not aborted");

	a_valve_serial: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_VALVE_SER, 8'h00)
		|=> rsp_r.data == $past(ident.valve_serial) && !rsp_r.abort)
		else $error("valve serial wrong");

	a_nmt_take: assert property (@(posedge clock) disable iff (sys_rst)
		s_write(`CID_IDX_NMT) ##0 req.subindex == 8'h00
		|=> nmt_strobe_r ##1 (!nmt_strobe_r || $past(req.valid)))
		else $error("network command not taken");

	a_name_const: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_NAME, 8'h00) |=> rsp_r.data == NAME_TEXT && !rsp_r.abort)
		else $error("device name wrong");

	a_vendor_code: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_IDENTITY, 8'h01) |=> rsp_r.data == VENDOR_CODE && !rsp_r.abort)
		else $error("vendor code wrong");

	a_product_code: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_IDENTITY, 8'h02) |=> rsp_r.data == $past(ident.product_code))
		else $error("product code wrong");

	a_ident_serial: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_IDENTITY, 8'h04) |=> rsp_r.data == $past(ident.product_serial))
		else $error("product serial misplaced");

	a_ident_type: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_IDENTITY, 8'h08) |=> rsp_r.data == $past(ident.valve_type))
		else $error("valve type misplaced");

	a_valve_part: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_VALVE_PART, 8'h00)
		|=> rsp_r.data == $past(ident.valve_code) && !rsp_r.abort)
		else $error("valve part code wrong");

	a_answer_one: assert property (@(posedge clock) disable iff (sys_rst)
		req.valid |=> rsp_r.valid)
		else $error("request left unanswered");

	a_answer_idle: assert property (@(posedge clock) disable iff (sys_rst)
		!req.valid |=> !rsp_r.valid && !rsp_r.abort && rsp_r.data == 32'h0000_0000)
		else $error("answer without request");

	a_cmd_read_abort: assert property (@(posedge clock) disable iff (sys_rst)
		s_read(`CID_IDX_NMT, 8'h00)
		|=> rsp_r.abort && rsp_r.abort_code == `CID_ABT_WRITE_ONLY)
		else $error("read of command object not aborted");

	a_cmd_value: assert property (@(posedge clock) disable iff (sys_rst)
		s_write(`CID_IDX_NMT) ##0 req.subindex == 8'h00
		|=> nmt_cmd_r == $past(req.wdata[15:0]))
		else $error("network command value lost");

endmodule : cid_dictionary

//--- test/cid_sdo_master.sv
// Network master model that issues SDO requests and keeps each answer.
`timescale 1ns/1ps

module cid_sdo_master import cid_pkg::*; (
	input wire logic clock,
	input wire logic go,
	input wire cid_req_t cmd,
	input wire cid_rsp_t rsp,
	output cid_req_t req,
	output cid_rsp_t ans
);
	// Request held for one cycle, idle lines show garbage
	always_comb begin
		req = ~cmd;
		req.valid = 1'b0;
		if (go) begin
			req = cmd;
			req.valid = 1'b1;
		end
	end

	// Answer kept until the next request
	always_ff @(posedge clock) begin
		if (go) begin
			ans <= '0;
		end else if (rsp.valid) begin
			ans <= rsp;
		end
	end
endmodule : cid_sdo_master

//--- test/canopen_identity_dictionary_tb.sv
// Self-checking bench of the object dictionary.
`timescale 1ns/1ps
`include "cid_cfg.svh"

module canopen_identity_dictionary_tb import cid_pkg::*;;
	localparam logic [31:0] VEND = 32'h0000_1234; // Arbitrary value
	localparam logic [31:0] NAME = 32'h5445_5354; // Arbitrary value, differs from the default
	logic clock;
	logic sys_rst;
	logic go;
	cid_req_t cmd;
	cid_req_t req;
	cid_rsp_t rsp_r;
	cid_rsp_t ans;
	cid_ident_t ident;
	logic [7:0] fault_summary;
	logic [15:0] heartbeat_period_ms;
	logic hb_pulse_r;
	logic [15:0] nmt_cmd_r;
	logic nmt_strobe_r;
	int fails = 0;
	int tests_run = 0;
	int hb_count = 0;
	int nmt_count = 0;

	cid_dictionary #(.MS_CYCLES(4), .VENDOR_CODE(VEND), .NAME_TEXT(NAME)) dut (
		.clock(clock), .sys_rst(sys_rst), .req(req), .ident(ident),
		.fault_summary(fault_summary), .heartbeat_period_ms(heartbeat_period_ms),
		.rsp_r(rsp_r), .hb_pulse_r(hb_pulse_r), .nmt_cmd_r(nmt_cmd_r),
		.nmt_strobe_r(nmt_strobe_r));

	cid_sdo_master master (.clock(clock), .go(go), .cmd(cmd), .rsp(rsp_r), .req(req), .ans(ans));

	// 250 MHz clock
	always #2 clock = ~clock;

	// Heartbeat and command pulse counters
	always @(posedge clock) begin
		if (hb_pulse_r === 1'b1) begin
			hb_count++;
		end
		if (nmt_strobe_r === 1'b1) begin
			nmt_count++;
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One request, answer taken one cycle after it
	task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd);
		@(posedge clock);
		go <= 1'b1;
		cmd <= '{1'b0, wr, idx, sub, wd};
		@(posedge clock);
		go <= 1'b0;
		@(posedge clock);
		#1;
	endtask : xfer

	task automatic rd(input string what, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] exp);
		xfer(1'b0, idx, sub, 32'h0000_0000);
		chk(what, (ans.valid && !ans.abort) ? ans.data : 32'hDEAD_BEEF, exp);
	endtask : rd

	task automatic ab(input string what, input logic wr, input logic [15:0] idx,
		input logic [7:0] sub, input logic [31:0] code);
		xfer(wr, idx, sub, 32'h0000_0077);
		chk(what, (ans.valid && ans.abort) ? ans.abort_code : 32'h0000_0000, code);
	endtask : ab

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize

	// Watchdog
	initial begin
		#4000;
		fails++;
		$display("[FAIL] watchdog expired");
		summarize();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		sys_rst = 1'b1;
		go = 1'b0;
		cmd = '0;
		fault_summary = 8'h5A;
		heartbeat_period_ms = 16'h0000;
		ident = '{32'h1234_5678, 32'h0000_1111, 32'h8765_4321, 32'h0000_2222,
			32'h0000_0033, 16'h0002, 8'h02, 1'b0, 8'h01, 1'b1};
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		rd("profile", 16'h1000, 8'h00, 32'h0000_0000);
		rd("fault", 16'h1001, 8'h00, 32'h0000_005A);
		rd("sync", 16'h1005, 8'h00, 32'h0000_0080);
		rd("name", 16'h1008, 8'h00, NAME);
		rd("period zero", 16'h1017, 8'h00, 32'h0000_0000);
		rd("entries", 16'h1018, 8'h00, 32'h0000_0008);
		rd("vendor", 16'h1018, 8'h01, VEND);
		rd("product", 16'h1018, 8'h02, 32'h1234_5678);
		rd("revision", 16'h1018, 8'h03, 32'h0002_0003);
		rd("serial", 16'h1018, 8'h04, 32'h0000_1111);
		rd("valve code", 16'h1018, 8'h05, 32'h8765_4321);
		rd("valve rev", 16'h1018, 8'h06, 32'h0000_0065);
		rd("valve serial", 16'h1018, 8'h07, 32'h0000_2222);
		rd("valve type", 16'h1018, 8'h08, 32'h0000_0033);
		rd("obj valve code", 16'h2049, 8'h00, 32'h8765_4321);
		rd("obj valve rev", 16'h204A, 8'h00, 32'h0000_0065);
		rd("obj valve serial", 16'h204B, 8'h00, 32'h0000_2222);
		// Preliminary part revision, released valve revision
		@(posedge clock);
		ident.part_rev_step <= 8'h03;
		ident.part_rev_prelim <= 1'b1;
		ident.valve_rev_step <= 8'h00;
		ident.valve_rev_prelim <= 1'b0;
		rd("prelim revision", 16'h1018, 8'h03, 32'h0002_0067);
		rd("release valve rev", 16'h1018, 8'h06, 32'h0000_0001);
		rd("obj release rev", 16'h204A, 8'h00, 32'h0000_0001);
		ab("write sync", 1'b1, 16'h1005, 8'h00, `CID_ABT_READ_ONLY);
		rd("sync kept", 16'h1005, 8'h00, 32'h0000_0080);
		ab("write vendor", 1'b1, 16'h1018, 8'h01, `CID_ABT_READ_ONLY);
		rd("vendor kept", 16'h1018, 8'h01, VEND);
		ab("write valve rev", 1'b1, 16'h204A, 8'h00, `CID_ABT_READ_ONLY);
		ab("no object", 1'b0, 16'h2000, 8'h00, `CID_ABT_NO_OBJECT);
		ab("sub on single", 1'b0, 16'h1000, 8'h01, `CID_ABT_NO_SUB);
		ab("sub past end", 1'b0, 16'h1018, 8'h09, `CID_ABT_NO_SUB);
		ab("read command", 1'b0, 16'h0000, 8'h00, `CID_ABT_WRITE_ONLY);
		ab("command sub", 1'b1, 16'h0000, 8'h01, `CID_ABT_NO_SUB);
		xfer(1'b1, 16'h0000, 8'h00, 32'h0000_0001);
		chk("command", {16'h0000, nmt_cmd_r}, 32'h0000_0001);
		chk("command ack", {30'h0, ans.valid, ans.abort}, 32'h0000_0002);
		chk("command strobes", nmt_count, 32'h0000_0001);
		// Heartbeat off, then two ms at four cycles per ms
		hb_count = 0;
		repeat (40) @(posedge clock);
		#1;
		chk("no heartbeat", hb_count, 32'h0000_0000);
		@(posedge clock);
		heartbeat_period_ms <= 16'h0002;
		rd("period", 16'h1017, 8'h00, 32'h0000_0002);
		repeat (12) @(posedge clock);
		#1;
		hb_count = 0;
		repeat (32) @(posedge clock);
		#1;
		chk("heartbeats", hb_count, 32'h0000_0004);
		// Period back to zero stops the heartbeat
		@(posedge clock);
		heartbeat_period_ms <= 16'h0000;
		rd("period off", 16'h1017, 8'h00, 32'h0000_0000);
		hb_count = 0;
		repeat (40) @(posedge clock);
		#1;
		chk("heartbeat stopped", hb_count, 32'h0000_0000);
		// Mid-run reset clears the command and every pulse
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		chk("reset command", {16'h0000, nmt_cmd_r}, 32'h0000_0000);
		chk("reset pulses", {29'h0, rsp_r.valid, nmt_strobe_r, hb_pulse_r}, 32'h0000_0000);
		@(posedge clock);
		sys_rst <= 1'b0;
		rd("sync after reset", 16'h1005, 8'h00, 32'h0000_0080);
		summarize();
	end
endmodule : canopen_identity_dictionary_tb
